// ===== verilog/gate_opt_pkg.sv
// constants, register map and carrier types of the gate option block
// assumes a 100 MHz system clock and an AXI4-Lite master with 8-bit addresses
package gate_opt_pkg;
  localparam int unsigned CLK_NS = 10;
  localparam int unsigned HALF_SEC_NS = 500000000;
  localparam int unsigned HALF_SEC_CYCLES = HALF_SEC_NS / CLK_NS;
  localparam int unsigned ENTER_HOLD_S = 2;
  localparam logic [2:0] ENTER_HALVES = 3'(2 * ENTER_HOLD_S + 1);
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_TIMES = 8'h04;
  localparam logic [7:0] OFF_CMD = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0c;
  localparam logic [7:0] OFF_CYCLES = 8'h10;
  localparam logic [7:0] OFF_MAINT = 8'h14;
  // CTRL fields
  localparam int BIT_RADIO = 0;
  localparam int BIT_ATG = 1;
  localparam int BIT_PAIR = 2;
  localparam int BIT_STAG_CLOSE = 3;
  localparam int POS_MOTOR = 4;
  localparam int POS_MSEL = 8;
  // TIMES fields
  localparam int POS_MID = 0;
  localparam int POS_STAG = 8;
  // CMD bits
  localparam int CMD_RESTORE = 0;
  localparam int CMD_CLR_MAINT = 1;
  localparam int CMD_LEARN = 2;
  localparam int CMD_DEL_ONE = 3;
  localparam int CMD_DEL_ALL = 4;
  localparam int CMD_ELEARN = 5;
  localparam int CMD_EDEL_ONE = 6;
  localparam int CMD_EDEL_ALL = 7;
  localparam int CMD_EMODE_STOP = 8;
  localparam logic RADIO_DEFAULT = 1'b1;
  localparam logic [1:0] MSEL_DEFAULT = 2'h1;
  localparam logic [2:0] MOTOR_DEFAULT = 3'h0;
  localparam logic [2:0] MOTOR_LAST = 3'h5;
  localparam logic [6:0] SECS_MAX = 7'h63;
  localparam logic [14:0] THR_5K = 15'h1388;
  localparam logic [14:0] THR_10K = 15'h2710;
  localparam logic [14:0] THR_15K = 15'h3a98;
  localparam logic [14:0] THR_25K = 15'h61a8;
  localparam logic [5:0] ACCESS_MAX = 6'h28;
  localparam logic [1:0] EDGE_MAX = 2'h2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [6:0] {
    ST_CLOSED = 7'h01, ST_OPEN_DLY = 7'h02, ST_OPENING = 7'h04, ST_HALTED = 7'h08,
    ST_CLOSE_DLY = 7'h10, ST_CLOSING = 7'h20, ST_SHADOW_STOP = 7'h40
  } gate_st_t;

  typedef struct packed {
    logic fire_dept, open_btn, close_btn, stop_btn, enter_btn, show_cycles, shadow_loop;
    logic reverse_loop, close_obstr, open_limit, close_limit, auto_close, peer_act, peer_ok, peer_dual;
  } gate_pins_t;

  typedef struct packed {
    logic awvalid; logic [7:0] awaddr; logic wvalid; logic [31:0] wdata; logic [3:0] wstrb;
    logic bready; logic arvalid; logic [7:0] araddr; logic rready;
  } axi_m2s_t;

  typedef struct packed {
    logic awready; logic wready; logic bvalid; logic [1:0] bresp;
    logic arready; logic rvalid; logic [31:0] rdata; logic [1:0] rresp;
  } axi_s2m_t;

  typedef struct packed {
    logic radio_en, atg, paired, stag_close;
    logic [2:0] motor;
    logic [1:0] msel;
    logic [6:0] mid, stag;
  } cfg_t;

  typedef struct packed {
    gate_pins_t s1, s2, prev;
    gate_st_t gst;
    logic [25:0] div;
    logic half, blink, full_req, scroll_half, due;
    logic [7:0] tcnt;
    logic [2:0] enter_cnt;
    logic [1:0] pair;
    logic [23:0] cycles;
    logic [14:0] maint;
    logic [7:0] disp;
    cfg_t cfg;
    logic [5:0] acc_cnt;
    logic [1:0] edge_cnt, edge_stop;
    logic aw_got, w_got;
    logic [7:0] aw_addr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    axi_s2m_t ax;
  } opt_state_t;
endpackage : gate_opt_pkg

// ===== verilog/gate_options.sv
// gate operator option logic: counters, mid-travel, anti-tailgate, radio gating, pairing
// assumes pins are asynchronous, radio decoder pulses and the AXI master share clk_sys
//
// Design decisions made here: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none

module gate_options #(
  parameter int unsigned HALF_CYCLES = gate_opt_pkg::HALF_SEC_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire gate_opt_pkg::axi_m2s_t axi_in,
  output gate_opt_pkg::axi_s2m_t axi_out,
  input wire gate_opt_pkg::gate_pins_t pins,
  input wire logic radio_access,
  input wire logic radio_edge,
  input wire logic radio_edge_idx,
  input wire logic nv_load,
  input wire logic [23:0] nv_cycles_in,
  input wire logic [14:0] nv_maint_in,
  output logic [23:0] nv_cycles_out,
  output logic [14:0] nv_maint_out,
  output logic motor_open,
  output logic motor_close,
  output logic [2:0] motor_type,
  output logic service_due_lamp,
  output logic [7:0] disp_digits,
  output logic peer_act_out,
  output logic peer_dual_out,
  output logic peer_link
);
  gate_opt_pkg::opt_state_t st_r, st_nxt;
  gate_opt_pkg::gate_pins_t s, p;
  logic paired_act, link_fail, fire, open_cmd, close_cmd, stop_cmd, edge_rev, edge_stop;
  logic clr_abs, clr_maint, thr_exceed, aw_hs, w_hs, ar_hs, mid_on, stag_on, close_go;
  logic [14:0] thr;
  logic [31:0] rd_word, merged, mask;
  logic rd_ok;

  function automatic logic [23:0] bcd_inc(input logic [23:0] v);
    logic [23:0] r;
    logic c;
    r = v;
    c = 1'b1;
    for (int i = 0; i < 6; i++)
    begin
      if (c)
      begin
        if (r[i*4 +: 4] == 4'h9)
        begin
          r[i*4 +: 4] = 4'h0;
        end
        else
        begin
          r[i*4 +: 4] = r[i*4 +: 4] + 4'h1;
          c = 1'b0;
        end
      end
    end
    return c ? v : r;  // saturate at 999999 rather than wrap
  endfunction : bcd_inc

  function automatic gate_opt_pkg::cfg_t cfg_defaults(input logic [2:0] motor);
    gate_opt_pkg::cfg_t c;
    c = '0;
    c.radio_en = gate_opt_pkg::RADIO_DEFAULT;
    c.msel = gate_opt_pkg::MSEL_DEFAULT;
    c.motor = motor;
    return c;
  endfunction : cfg_defaults

  always_comb
  begin
    s = st_r.s2;
    p = st_r.prev;
    paired_act = st_r.cfg.paired & s.peer_dual;
    link_fail = paired_act & ~s.peer_ok;
    fire = s.fire_dept;
    edge_rev = radio_edge & st_r.cfg.radio_en & ({1'b0, radio_edge_idx} < st_r.edge_cnt)
      & ~st_r.edge_stop[radio_edge_idx];
    edge_stop = radio_edge & st_r.cfg.radio_en & ({1'b0, radio_edge_idx} < st_r.edge_cnt)
      & st_r.edge_stop[radio_edge_idx];
    open_cmd = (s.open_btn & ~p.open_btn) | (paired_act & s.peer_act & ~p.peer_act)
      | (radio_access & st_r.cfg.radio_en & (st_r.acc_cnt != 6'h0));
    close_cmd = (s.close_btn & ~p.close_btn) | (s.auto_close & ~p.auto_close);
    stop_cmd = (s.stop_btn & ~p.stop_btn) | edge_stop;
    mid_on = (st_r.cfg.mid != 7'h0) & ~paired_act;
    stag_on = paired_act & (st_r.cfg.stag != 7'h0);
    close_go = close_cmd | (st_r.cfg.atg & p.shadow_loop & ~s.shadow_loop);
    case (st_r.cfg.msel)
      2'h0: thr = gate_opt_pkg::THR_5K;
      2'h1: thr = gate_opt_pkg::THR_10K;
      2'h2: thr = gate_opt_pkg::THR_15K;
      default: thr = gate_opt_pkg::THR_25K;
    endcase
    thr_exceed = st_r.maint > thr;
    clr_abs = s.show_cycles & s.enter_btn & st_r.half
      & (st_r.enter_cnt == gate_opt_pkg::ENTER_HALVES - 3'h1);
    aw_hs = axi_in.awvalid & st_r.ax.awready;
    w_hs = axi_in.wvalid & st_r.ax.wready;
    ar_hs = axi_in.arvalid & st_r.ax.arready;
    for (int i = 0; i < 4; i++)
    begin
      mask[i*8 +: 8] = {8{st_r.wstrb[i]}};
    end
    rd_ok = 1'b1;
    case (axi_in.araddr & 8'hfc)
      gate_opt_pkg::OFF_CTRL: rd_word = 32'({st_r.cfg.msel, 1'b0, st_r.cfg.motor, st_r.cfg.stag_close,
        st_r.cfg.paired, st_r.cfg.atg, st_r.cfg.radio_en});
      gate_opt_pkg::OFF_TIMES: rd_word = 32'({1'b0, st_r.cfg.stag, 1'b0, st_r.cfg.mid});
      gate_opt_pkg::OFF_CMD: rd_word = 32'h0;
      gate_opt_pkg::OFF_STATUS: rd_word = 32'({peer_link, link_fail,
        (st_r.edge_cnt != 2'h0) & st_r.cfg.radio_en, (st_r.edge_cnt < gate_opt_pkg::EDGE_MAX) & st_r.cfg.radio_en,
        (st_r.acc_cnt != 6'h0) & st_r.cfg.radio_en, (st_r.acc_cnt < gate_opt_pkg::ACCESS_MAX) & st_r.cfg.radio_en,
        st_r.due, st_r.edge_cnt, st_r.acc_cnt});
      gate_opt_pkg::OFF_CYCLES: rd_word = 32'(st_r.cycles);
      gate_opt_pkg::OFF_MAINT: rd_word = 32'(st_r.maint);
      default:
      begin
        rd_word = 32'h0;
        rd_ok = 1'b0;
      end
    endcase
  end

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.s1 = pins;
    st_nxt.s2 = st_r.s1;
    st_nxt.prev = st_r.s2;
    st_nxt.half = (st_r.div == 26'(HALF_CYCLES - 1));
    st_nxt.div = st_nxt.half ? 26'h0 : st_r.div + 26'h1;
    if (st_r.half)
    begin
      st_nxt.blink = ~st_r.blink;
      st_nxt.tcnt = (st_r.tcnt == 8'hff) ? st_r.tcnt : st_r.tcnt + 8'h1;
    end
    clr_maint = 1'b0;
    merged = 32'h0;
    // gate motion; fire overrides link failure and mid-travel
    case (st_r.gst)
      gate_opt_pkg::ST_CLOSED:
      begin
        st_nxt.tcnt = 8'h0;
        st_nxt.full_req = fire;
        if (fire)
          st_nxt.gst = gate_opt_pkg::ST_OPENING;
        else if (open_cmd && !link_fail)
          st_nxt.gst = (stag_on && !st_r.cfg.stag_close) ? gate_opt_pkg::ST_OPEN_DLY : gate_opt_pkg::ST_OPENING;
      end
      gate_opt_pkg::ST_OPEN_DLY:
      begin
        if (fire || (st_r.half && st_r.tcnt + 8'h1 >= {st_r.cfg.stag, 1'b0}))
        begin
          st_nxt.gst = gate_opt_pkg::ST_OPENING;
          st_nxt.tcnt = 8'h0;
          st_nxt.full_req = fire;
        end
        else if (stop_cmd || link_fail)
          st_nxt.gst = gate_opt_pkg::ST_CLOSED;
      end
      gate_opt_pkg::ST_OPENING:
      begin
        st_nxt.full_req = st_r.full_req | fire;
        if (s.open_limit)
          st_nxt.gst = gate_opt_pkg::ST_HALTED;
        else if (!fire && (stop_cmd || link_fail))
          st_nxt.gst = gate_opt_pkg::ST_HALTED;
        else if (mid_on && !st_r.full_req && !fire && st_r.tcnt >= {st_r.cfg.mid, 1'b0})
        begin
          if (s.open_btn)
            st_nxt.full_req = 1'b1;
          else
            st_nxt.gst = gate_opt_pkg::ST_HALTED;
        end
      end
      gate_opt_pkg::ST_HALTED:
      begin
        st_nxt.tcnt = 8'h0;
        if (fire && !s.open_limit)
        begin
          st_nxt.gst = gate_opt_pkg::ST_OPENING;
          st_nxt.full_req = 1'b1;
        end
        else if (!fire && !link_fail && open_cmd && !s.open_limit)
        begin
          st_nxt.gst = gate_opt_pkg::ST_OPENING;
          st_nxt.full_req = 1'b1;
        end
        else if (!fire && !link_fail && close_go && !s.shadow_loop)
          st_nxt.gst = (stag_on && st_r.cfg.stag_close) ? gate_opt_pkg::ST_CLOSE_DLY : gate_opt_pkg::ST_CLOSING;
      end
      gate_opt_pkg::ST_CLOSE_DLY:
      begin
        if (fire)
        begin
          st_nxt.gst = gate_opt_pkg::ST_OPENING;
          st_nxt.full_req = 1'b1;
        end
        else if (stop_cmd || link_fail)
          st_nxt.gst = gate_opt_pkg::ST_HALTED;
        else if (st_r.half && st_r.tcnt + 8'h1 >= {st_r.cfg.stag, 1'b0})
          st_nxt.gst = gate_opt_pkg::ST_CLOSING;
      end
      gate_opt_pkg::ST_CLOSING, gate_opt_pkg::ST_SHADOW_STOP:
      begin
        if (st_r.gst == gate_opt_pkg::ST_CLOSING && s.close_limit)
        begin
          st_nxt.gst = gate_opt_pkg::ST_CLOSED;
          st_nxt.cycles = bcd_inc(st_r.cycles);
          st_nxt.maint = (st_r.maint == 15'h7fff) ? st_r.maint : st_r.maint + 15'h1;
        end
        else if (fire || s.close_obstr || s.reverse_loop || edge_rev)
        begin
          st_nxt.gst = gate_opt_pkg::ST_OPENING;
          st_nxt.tcnt = 8'h0;
          st_nxt.full_req = 1'b1;
        end
        else if (stop_cmd || link_fail)
          st_nxt.gst = gate_opt_pkg::ST_HALTED;
        else if (st_r.cfg.atg && s.shadow_loop)
          st_nxt.gst = gate_opt_pkg::ST_SHADOW_STOP;
        else
          st_nxt.gst = gate_opt_pkg::ST_CLOSING;
      end
      default: st_nxt.gst = gate_opt_pkg::ST_HALTED;
    endcase
    // cycle display and clearing
    if (s.show_cycles)
    begin
      if (st_r.half)
      begin
        st_nxt.scroll_half = ~st_r.scroll_half;
        if (st_r.scroll_half)
          st_nxt.pair = (st_r.pair == 2'h2) ? 2'h0 : st_r.pair + 2'h1;
      end
      case (st_r.pair)
        2'h0: st_nxt.disp = st_r.cycles[23:16];
        2'h1: st_nxt.disp = st_r.cycles[15:8];
        default: st_nxt.disp = st_r.cycles[7:0];
      endcase
    end
    else
    begin
      st_nxt.pair = 2'h0;
      st_nxt.scroll_half = 1'b0;
      st_nxt.disp = 8'h0;
    end
    if (!(s.show_cycles && s.enter_btn))
      st_nxt.enter_cnt = 3'h0;
    else if (st_r.half && st_r.enter_cnt != gate_opt_pkg::ENTER_HALVES)
      st_nxt.enter_cnt = st_r.enter_cnt + 3'h1;
    if (clr_abs)
      st_nxt.cycles = 24'h0;
    // bus write, one at a time; both halves may arrive in either order
    st_nxt.ax.awready = ~st_nxt.aw_got & ~st_nxt.ax.bvalid;
    if (aw_hs)
    begin
      st_nxt.aw_got = 1'b1;
      st_nxt.aw_addr = axi_in.awaddr;
    end
    if (w_hs)
    begin
      st_nxt.w_got = 1'b1;
      st_nxt.wdata = axi_in.wdata;
      st_nxt.wstrb = axi_in.wstrb;
    end
    if (st_r.ax.bvalid && axi_in.bready)
      st_nxt.ax.bvalid = 1'b0;
    if (st_r.aw_got && st_r.w_got)
    begin
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got = 1'b0;
      st_nxt.ax.bvalid = 1'b1;
      st_nxt.ax.bresp = gate_opt_pkg::RESP_OKAY;
      case (st_r.aw_addr & 8'hfc)
        gate_opt_pkg::OFF_CTRL:
        begin
          merged = (32'({st_r.cfg.msel, 1'b0, st_r.cfg.motor, st_r.cfg.stag_close, st_r.cfg.paired, st_r.cfg.atg,
            st_r.cfg.radio_en}) & ~mask) | (st_r.wdata & mask);
          st_nxt.cfg.radio_en = merged[gate_opt_pkg::BIT_RADIO];
          st_nxt.cfg.atg = merged[gate_opt_pkg::BIT_ATG];
          st_nxt.cfg.paired = merged[gate_opt_pkg::BIT_PAIR];
          st_nxt.cfg.stag_close = merged[gate_opt_pkg::BIT_STAG_CLOSE];
          st_nxt.cfg.msel = merged[gate_opt_pkg::POS_MSEL +: 2];
          if (merged[gate_opt_pkg::POS_MOTOR +: 3] <= gate_opt_pkg::MOTOR_LAST)
            st_nxt.cfg.motor = merged[gate_opt_pkg::POS_MOTOR +: 3];
        end
        gate_opt_pkg::OFF_TIMES:
        begin
          merged = (32'({1'b0, st_r.cfg.stag, 1'b0, st_r.cfg.mid}) & ~mask) | (st_r.wdata & mask);
          if (merged[gate_opt_pkg::POS_MID +: 7] <= gate_opt_pkg::SECS_MAX)
            st_nxt.cfg.mid = merged[gate_opt_pkg::POS_MID +: 7];
          if (merged[gate_opt_pkg::POS_STAG +: 7] <= gate_opt_pkg::SECS_MAX)
            st_nxt.cfg.stag = merged[gate_opt_pkg::POS_STAG +: 7];
        end
        gate_opt_pkg::OFF_CMD:
        begin
          merged = st_r.wdata & mask;
          if (merged[gate_opt_pkg::CMD_RESTORE])
            st_nxt.cfg = cfg_defaults(st_r.cfg.motor);
          clr_maint = merged[gate_opt_pkg::CMD_CLR_MAINT];
          if (st_r.cfg.radio_en)
          begin
            if (merged[gate_opt_pkg::CMD_LEARN] && st_r.acc_cnt < gate_opt_pkg::ACCESS_MAX)
              st_nxt.acc_cnt = st_r.acc_cnt + 6'h1;
            else if (merged[gate_opt_pkg::CMD_DEL_ALL])
              st_nxt.acc_cnt = 6'h0;
            else if (merged[gate_opt_pkg::CMD_DEL_ONE] && st_r.acc_cnt != 6'h0)
              st_nxt.acc_cnt = st_r.acc_cnt - 6'h1;
            if (merged[gate_opt_pkg::CMD_ELEARN] && st_r.edge_cnt < gate_opt_pkg::EDGE_MAX)
            begin
              st_nxt.edge_stop[st_r.edge_cnt[0]] = merged[gate_opt_pkg::CMD_EMODE_STOP];
              st_nxt.edge_cnt = st_r.edge_cnt + 2'h1;
            end
            else if (merged[gate_opt_pkg::CMD_EDEL_ALL])
              st_nxt.edge_cnt = 2'h0;
            else if (merged[gate_opt_pkg::CMD_EDEL_ONE] && st_r.edge_cnt != 2'h0)
              st_nxt.edge_cnt = st_r.edge_cnt - 2'h1;
          end
        end
        default: st_nxt.ax.bresp = gate_opt_pkg::RESP_SLVERR;
      endcase
    end
    st_nxt.ax.awready = ~st_nxt.aw_got & ~st_nxt.ax.bvalid;
    st_nxt.ax.wready = ~st_nxt.w_got & ~st_nxt.ax.bvalid;
    if (st_r.ax.rvalid && axi_in.rready)
      st_nxt.ax.rvalid = 1'b0;
    if (ar_hs)
    begin
      st_nxt.ax.rvalid = 1'b1;
      st_nxt.ax.rdata = rd_word;
      st_nxt.ax.rresp = rd_ok ? gate_opt_pkg::RESP_OKAY : gate_opt_pkg::RESP_SLVERR;
    end
    st_nxt.ax.arready = ~st_nxt.ax.rvalid;
    if (clr_maint)
      st_nxt.maint = 15'h0;
    if (nv_load)
    begin
      st_nxt.cycles = nv_cycles_in;
      st_nxt.maint = nv_maint_in;
    end
    // a new excess wins over a clear in the same cycle
    if (clr_abs)
      st_nxt.due = 1'b0;
    if (thr_exceed)
      st_nxt.due = 1'b1;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      st_r <= '0;
      st_r.gst <= gate_opt_pkg::ST_CLOSED;
      st_r.cfg <= cfg_defaults(gate_opt_pkg::MOTOR_DEFAULT);
    end
    else
      st_r <= st_nxt;
  end

  assign axi_out = st_r.ax;
  assign nv_cycles_out = st_r.cycles;
  assign nv_maint_out = st_r.maint;
  assign motor_open = (st_r.gst == gate_opt_pkg::ST_OPENING);
  assign motor_close = (st_r.gst == gate_opt_pkg::ST_CLOSING);
  assign motor_type = st_r.cfg.motor;
  assign service_due_lamp = st_r.due;
  assign disp_digits = st_r.disp;
  assign peer_act_out = (st_r.gst == gate_opt_pkg::ST_OPEN_DLY) | motor_open;
  assign peer_dual_out = st_r.cfg.paired;
  assign peer_link = link_fail ? st_r.blink : paired_act;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_cycle_count: assert property ((st_r.gst == gate_opt_pkg::ST_CLOSING) && s.close_limit && !clr_abs && !nv_load
    && st_r.cycles != 24'h999999 |=> st_r.cycles != $past(st_r.cycles)) else $error("cycle not counted");
  a_scroll_start: assert property ($rose(s.show_cycles) |=> st_r.pair == 2'h0) else $error("scroll not msb");
  a_enter_hold: assert property ($fell(st_r.cycles != 24'h0) && !$past(nv_load)
    |-> $past(st_r.enter_cnt) == gate_opt_pkg::ENTER_HALVES - 3'h1) else $error("early clear");
  a_due_cleared: assert property (clr_abs && !thr_exceed |=> !st_r.due) else $error("alert kept");
  a_due_set: assert property (thr_exceed |=> service_due_lamp) else $error("lamp not lit");
  a_maint_indep: assert property (clr_maint && !nv_load && !clr_abs |=> st_r.maint == 15'h0
    && st_r.cycles == $past(st_r.cycles)) else $error("maint clear wrong");
  a_fire_full: assert property (motor_open && fire && !s.open_limit |=> motor_open [*2])
    else $error("fire open stopped");
  a_paired_no_mid: assert property (motor_open && paired_act && !s.open_limit && !stop_cmd && !link_fail
    |=> st_r.gst != gate_opt_pkg::ST_HALTED) else $error("mid stop when paired");
  a_atg_off: assert property (st_r.gst == gate_opt_pkg::ST_HALTED && !st_r.cfg.atg && !close_cmd
    |=> !motor_close && st_r.gst != gate_opt_pkg::ST_CLOSE_DLY) else $error("closed without command");
  a_shadow_stop: assert property (motor_close && st_r.cfg.atg && s.shadow_loop && !s.close_limit && !fire
    && !s.close_obstr && !s.reverse_loop && !edge_rev && !stop_cmd && !link_fail
    |=> st_r.gst == gate_opt_pkg::ST_SHADOW_STOP) else $error("shadow did not stop");
  a_radio_off: assert property (!st_r.cfg.radio_en |=> $stable(st_r.acc_cnt) && $stable(st_r.edge_cnt))
    else $error("memory changed while off");
  a_limits: assert property (st_r.acc_cnt <= gate_opt_pkg::ACCESS_MAX && st_r.edge_cnt <= gate_opt_pkg::EDGE_MAX
    && st_r.cfg.motor <= gate_opt_pkg::MOTOR_LAST) else $error("limit exceeded");
  a_link_refuse: assert property (link_fail && st_r.gst == gate_opt_pkg::ST_CLOSED && !fire
    |=> st_r.gst == gate_opt_pkg::ST_CLOSED) else $error("ran on failed link");
  c_full_cycle: cover property (motor_close ##1 st_r.gst == gate_opt_pkg::ST_CLOSED);
  c_mid_stop: cover property (motor_open && mid_on ##1 st_r.gst == gate_opt_pkg::ST_HALTED && !s.open_limit);
  c_shadow_resume: cover property (st_r.gst == gate_opt_pkg::ST_SHADOW_STOP ##1 motor_close);
  c_count_clear: cover property (clr_abs);
endmodule : gate_options

`default_nettype wire

// ===== tb/peer_model.sv
// peer operator model on the three-wire link
// assumes the bench decides when the link is lost
`timescale 1ns/1ps
`default_nettype none
module peer_model (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic act_in,
  input wire logic link_up,
  output logic [2:0] link_pins
);
  logic act_r;
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      act_r <= 1'b0;
    else
      act_r <= act_in & link_up;
  end
  // act, ok, dual; a lost link cannot carry an activation
  assign link_pins = {act_r, link_up, 1'b1};
endmodule : peer_model
`default_nettype wire

// ===== tb/testbench.sv
// bench for gate_options: registers, counters, mid-travel, link failure
// assumes HALF_CYCLES shortened to 8 and the peer model on the link pins
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic link_up = 1'b1;
  logic nv_load = 1'b0;
  logic [23:0] nv_c = '0;
  logic [14:0] nv_m = '0;
  gate_opt_pkg::axi_m2s_t m = '0;
  gate_opt_pkg::axi_s2m_t s;
  gate_opt_pkg::gate_pins_t p = '0;
  logic [2:0] peer_w;
  logic mo, mc, lamp, pact;
  logic ra = 1'b0;
  logic [7:0] dd;
  logic [31:0] d, cyc;
  logic [1:0] r;
  int failures = 0;
  int n_compared = 0;
  initial forever #5 clk_sys = ~clk_sys;
  gate_options #(.HALF_CYCLES(8)) gate_options_inst (.clk_sys(clk_sys), .rst_n(rst_n), .axi_in(m), .axi_out(s),
    .pins({p[14:3], peer_w}), .radio_access(ra), .radio_edge(1'b0), .radio_edge_idx(1'b0), .nv_load(nv_load),
    .nv_cycles_in(nv_c), .nv_maint_in(nv_m), .nv_cycles_out(), .nv_maint_out(), .motor_open(mo), .motor_close(mc),
    .motor_type(), .service_due_lamp(lamp), .disp_digits(dd), .peer_act_out(pact), .peer_dual_out(), .peer_link());
  peer_model peer_model_inst (.clk_sys(clk_sys), .rst_n(rst_n), .act_in(pact), .link_up(link_up), .link_pins(peer_w));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    m.awvalid <= 1'b1;
    m.awaddr <= a;
    m.wvalid <= 1'b1;
    m.wdata <= v;
    m.wstrb <= 4'hf;
    m.bready <= 1'b1;
    forever
    begin
      @(posedge clk_sys);
      if (s.awready) m.awvalid <= 1'b0;
      if (s.wready) m.wvalid <= 1'b0;
      if (s.bvalid) break;
    end
    m.bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    m.arvalid <= 1'b1;
    m.araddr <= a;
    m.rready <= 1'b1;
    forever
    begin
      @(posedge clk_sys);
      if (s.arready) m.arvalid <= 1'b0;
      if (s.rvalid) break;
    end
    d = s.rdata;
    r = s.rresp;
    m.rready <= 1'b0;
  endtask : rd
  // pins pass a synchronizer, so each pulse is held well past its latency
  task automatic hit(input int b);
    @(posedge clk_sys);
    p[b] <= 1'b1;
    repeat (8) @(posedge clk_sys);
    p[b] <= 1'b0;
    repeat (8) @(posedge clk_sys);
  endtask : hit
  function automatic logic [23:0] bcd_inc(input logic [23:0] v);
    logic [23:0] o;
    o = v;
    for (int i = 0; i < 6; i++)
    begin
      if (o[4*i+:4] != 4'h9)
      begin
        o[4*i+:4] = o[4*i+:4] + 4'h1;
        return o;
      end
      o[4*i+:4] = 4'h0;
    end
    return v;
  endfunction : bcd_inc
  task automatic print_verdict();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    failures++;
    print_verdict();
  end
  initial
  begin
    void'($urandom(66));
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rd(gate_opt_pkg::OFF_CTRL);
    chk(d, 32'h101);
    rd(8'h20);
    chk(r, gate_opt_pkg::RESP_SLVERR);
    rd(gate_opt_pkg::OFF_STATUS);
    chk(d[12:9], 4'h5);
    for (int k = 0; k < 8; k++)
    begin
      wr(gate_opt_pkg::OFF_CTRL, 32'h1 | (k << 4));
      rd(gate_opt_pkg::OFF_CTRL);
      chk(d[6:4], k > 5 ? 3'h5 : 3'(k));
    end
    wr(gate_opt_pkg::OFF_CTRL, 32'h323);
    wr(gate_opt_pkg::OFF_CMD, 32'h1);
    rd(gate_opt_pkg::OFF_CTRL);
    chk(d, 32'h121);
    wr(gate_opt_pkg::OFF_CTRL, 32'h120);
    rd(gate_opt_pkg::OFF_STATUS);
    chk(d[12:9], 4'h0);
    $display("test options done");
    wr(gate_opt_pkg::OFF_CTRL, 32'h1);
    wr(gate_opt_pkg::OFF_TIMES, 32'h1);
    hit(13);
    repeat (24) @(posedge clk_sys);
    chk(mo, 1'b0);
    hit(12);
    hit(4);
    wr(gate_opt_pkg::OFF_TIMES, 32'h0);
    $display("test midtravel done");
    for (int i = 0; i < 6; i++) cyc[4*i+:4] = 4'($urandom % 10);
    nv_c <= cyc[23:0];
    nv_m <= gate_opt_pkg::THR_5K;
    nv_load <= 1'b1;
    @(posedge clk_sys);
    nv_load <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk(lamp, 1'b0);
    hit(13);
    chk(mo, 1'b1);
    hit(5);
    hit(12);
    chk(mc, 1'b1);
    hit(4);
    chk(lamp, 1'b1);
    rd(gate_opt_pkg::OFF_CYCLES);
    chk(d, {8'h0, bcd_inc(cyc[23:0])});
    wr(gate_opt_pkg::OFF_CMD, 32'h2);
    rd(gate_opt_pkg::OFF_MAINT);
    chk(d, 32'h0);
    rd(gate_opt_pkg::OFF_CYCLES);
    chk(d, {8'h0, bcd_inc(cyc[23:0])});
    p[9] <= 1'b1;
    p[10] <= 1'b1;
    repeat (6) @(posedge clk_sys);
    chk(dd, 32'(bcd_inc(cyc[23:0]) >> 16));
    repeat (74) @(posedge clk_sys);
    p[10] <= 1'b0;
    p[9] <= 1'b0;
    rd(gate_opt_pkg::OFF_CYCLES);
    chk(d, 32'h0);
    chk(lamp, 1'b0);
    $display("test counters done");
    wr(gate_opt_pkg::OFF_CMD, 32'h4);
    @(posedge clk_sys);
    ra <= 1'b1;
    @(posedge clk_sys);
    ra <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk(mo, 1'b1);
    hit(5);
    $display("test radio done");
    wr(gate_opt_pkg::OFF_CTRL, 32'h105);
    link_up <= 1'b0;
    repeat (10) @(posedge clk_sys);
    rd(gate_opt_pkg::OFF_STATUS);
    chk(d[13], 1'b1);
    $display("test link done");
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
